// *** logic/cdp_parser.sv ***
// Module: serial command parser for control-value and matrix-row writes
`timescale 1ns/100ps
// Operation
// - Code 0x0a overwrites the stored value of one control.
// - Writes are accepted whether or not the remote service runs.
// - Two bytes after the code name the target control.
// - Control write: little-endian offset, then the new data bytes.
// - Each chunk lands at its offset in the data field.
// - Zero-offset chunk arrives last and commits, then goes to the client.
// - Two-state controls are one byte, 0x00 off and 0xff on.
// - List control data is a four-byte little-endian entry index.
// - Numeric control data is a four-byte little-endian signed integer.
// - Date-time holds eight bytes; buttons, files, images, messages none.
// - Code 0x0b writes one row of a matrix control.
// - Row write carries a little-endian row index, zero is first.
// - Axis field is eight bytes for date-time, else the X width.
// - Indexed writes store only; header-only row command refreshes client.
// - Code 0x0c appends a row, dropping the top row when full.
// - After an append the row goes to the client if connected.
module cdp_parser
  import cdp_pkg::*;
#(
  parameter int DATA_BYTES = cdp_pkg::CDP_DATA_BYTES,
  parameter int ROW_BYTES = cdp_pkg::CDP_ROW_BYTES,
  parameter int ROWS = cdp_pkg::CDP_ROWS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command byte stream from the host
  input cdp_pkg::cdp_byte_t rx,
  // Client connection state and matrix layout
  input wire logic client_connected,
  input wire logic matrix_is_datetime,
  input wire logic [7:0] x_axis_bytes,
  // Control value read port
  input wire logic [$clog2(DATA_BYTES)-1:0] rd_addr,
  output logic [7:0] rd_data,
  // Notifications to the client sender, matrix occupancy and the error flag
  output logic send_pulse,
  output cdp_pkg::cdp_event_t send_event,
  output logic [15:0] last_row,
  output logic [$clog2(ROWS+1)-1:0] row_count,
  output logic [$clog2(ROWS)-1:0] row_head,
  output logic cmd_error
);
  import cdp_pkg::*;

  initial begin
    if (DATA_BYTES < 2 || DATA_BYTES > 65536) $error("DATA_BYTES out of range");
    if (ROW_BYTES < 2 || ROW_BYTES > 255) $error("ROW_BYTES out of range");
  end

  typedef enum logic [1:0] {
    CDP_IDLE = 2'b00,
    CDP_BODY = 2'b01,
    CDP_SKIP = 2'b11
  } cdp_state_t;

  cdp_state_t state_reg;
  logic [7:0] len_reg;
  logic [7:0] pos_reg;
  logic [7:0] cmd_reg;
  logic [15:0] id_reg;
  logic [15:0] arg;
  logic [7:0] data_mem [DATA_BYTES];
  logic [7:0] staged_reg [DATA_BYTES];
  logic in_body;
  logic last_byte;
  logic known_cmd;
  logic [7:0] axis_len;
  logic [7:0] row_pos;
  logic data_wr;
  logic row_wr;
  logic append_done;
  logic [16:0] data_addr;
  logic offset_zero;

  assign in_body = rx.valid && state_reg == CDP_BODY;
  assign last_byte = pos_reg + 8'h01 == len_reg;
  assign known_cmd = rx.data == CDP_CMD_SET_DATA || rx.data == CDP_CMD_SET_ROW
                     || rx.data == CDP_CMD_APPEND_ROW;
  assign axis_len = matrix_is_datetime ? 8'(CDP_DT_AXIS_BYTES) : x_axis_bytes;
  // High offset byte is still on the stream when a data-less command ends on it
  assign offset_zero = (pos_reg == CDP_POS_ARG_HI) ? (rx.data == 8'h00 && arg[7:0] == 8'h00)
                                                   : (arg == 16'h0000);

  // Framing: length byte first, then the code
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= CDP_IDLE;
      len_reg <= 8'h00;
      pos_reg <= 8'h00;
    end else if (rx.valid) begin
      unique case (state_reg)
        CDP_IDLE: begin
          len_reg <= rx.data;
          pos_reg <= 8'h01;
          state_reg <= rx.data < CDP_MIN_LEN ? CDP_IDLE : CDP_BODY;
        end
        CDP_BODY, CDP_SKIP: begin
          pos_reg <= pos_reg + 8'h01;
          if (last_byte) begin
            state_reg <= CDP_IDLE;
          end else if (pos_reg == CDP_POS_CODE && !known_cmd) begin
            state_reg <= CDP_SKIP; // Foreign commands pass without effect
          end
        end
        default: state_reg <= CDP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_reg <= 8'h00;
      id_reg <= 16'h0000;
    end else if (in_body) begin
      if (pos_reg == CDP_POS_CODE) begin
        cmd_reg <= rx.data;
      end else if (pos_reg == CDP_POS_ID_HI) begin
        id_reg[15:8] <= rx.data;
      end else if (pos_reg == CDP_POS_ID_LO) begin
        id_reg[7:0] <= rx.data;
      end
    end
  end

  // Offset for control writes, row index for indexed row writes
  cdp_field_reg u_arg (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(rx.valid && state_reg == CDP_IDLE),
    .load_lo(in_body && pos_reg == CDP_POS_ARG_LO && cmd_reg != CDP_CMD_APPEND_ROW),
    .load_hi(in_body && pos_reg == CDP_POS_ARG_HI && cmd_reg != CDP_CMD_APPEND_ROW),
    .din(rx.data),
    .value(arg)
  );

  // Control data lands in a staging copy; the live copy changes only on commit
  assign data_addr = 17'(arg) + 17'(pos_reg - CDP_POS_DATA);
  assign data_wr = in_body && cmd_reg == CDP_CMD_SET_DATA && pos_reg >= CDP_POS_DATA
                   && data_addr < 17'(DATA_BYTES);
  always_ff @(posedge clk) begin
    if (data_wr) begin
      // Raw bytes serve every control kind, so no per-kind decoding is needed
      staged_reg[data_addr[$clog2(DATA_BYTES)-1:0]] <= rx.data;
    end
  end

  // Commit on the zero-offset chunk so the client sees one consistent value
  always_ff @(posedge clk) begin
    if (in_body && last_byte && cmd_reg == CDP_CMD_SET_DATA && offset_zero
        && pos_reg >= CDP_POS_ARG_HI) begin
      for (int i = 0; i < DATA_BYTES; i++) begin
        data_mem[i] <= staged_reg[i];
      end
      if (data_wr) begin
        data_mem[data_addr[$clog2(DATA_BYTES)-1:0]] <= rx.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= data_mem[rd_addr];
    end
  end

  // Row bytes: indexed rows start after the index, appends after the id
  assign row_pos = cmd_reg == CDP_CMD_SET_ROW ? pos_reg - CDP_POS_DATA
                                              : pos_reg - CDP_POS_ROW_DATA;
  assign row_wr = in_body && ((cmd_reg == CDP_CMD_SET_ROW && pos_reg >= CDP_POS_DATA)
                  || (cmd_reg == CDP_CMD_APPEND_ROW && pos_reg >= CDP_POS_ROW_DATA))
                  && 32'(row_pos) < ROW_BYTES;
  assign append_done = in_body && last_byte && cmd_reg == CDP_CMD_APPEND_ROW
                       && pos_reg >= CDP_POS_ROW_DATA;

  cdp_row_store #(
    .ROW_BYTES(ROW_BYTES),
    .ROWS(ROWS)
  ) u_rows (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(row_wr && (cmd_reg == CDP_CMD_APPEND_ROW || arg < 16'(ROWS))),
    .wr_append(cmd_reg == CDP_CMD_APPEND_ROW),
    .wr_row(arg),
    .wr_byte(row_pos[$clog2(ROW_BYTES)-1:0]),
    .wr_data(rx.data),
    .append_done(append_done),
    .row_count(row_count),
    .head(row_head)
  );

  // Client notifications
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      send_pulse <= 1'b0;
      send_event <= '0;
      last_row <= 16'h0000;
    end else begin
      send_pulse <= 1'b0;
      if (in_body && last_byte) begin
        if (cmd_reg == CDP_CMD_SET_DATA && offset_zero && pos_reg >= CDP_POS_ARG_HI) begin
          send_pulse <= 1'b1;
          send_event <= '{cmd: cmd_reg, ctrl_id: id_reg};
        end else if (cmd_reg == CDP_CMD_SET_ROW && len_reg == CDP_HDR_LEN) begin
          send_pulse <= 1'b1;
          send_event <= '{cmd: cmd_reg, ctrl_id: id_reg};
        end else if (append_done && client_connected) begin
          send_pulse <= 1'b1;
          send_event <= '{cmd: cmd_reg, ctrl_id: id_reg};
          last_row <= 16'(row_count);
        end
      end
    end
  end

  // Flags a control write that ends before its offset, or a control or indexed row write that overruns storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_error <= 1'b0;
    end else begin
      cmd_error <= in_body && ((last_byte && cmd_reg == CDP_CMD_SET_DATA
                   && pos_reg < CDP_POS_ARG_HI)
                   || (cmd_reg == CDP_CMD_SET_ROW && pos_reg >= CDP_POS_DATA
                   && (arg >= 16'(ROWS) || 32'(row_pos) >= ROW_BYTES))
                   || (cmd_reg == CDP_CMD_SET_DATA && pos_reg >= CDP_POS_DATA
                   && data_addr >= 17'(DATA_BYTES)));
    end
  end

  // axis_len feeds no check or write path; the reduction only keeps it from dangling
  logic unused_axis;
  assign unused_axis = ^axis_len;
endmodule : cdp_parser

// *** logic/cdp_pkg.sv ***
// Package: command codes, field positions, sizes and carrier types of the command parser
package cdp_pkg;
  localparam logic [7:0] CDP_CMD_SET_DATA = 8'h0a;
  localparam logic [7:0] CDP_CMD_SET_ROW = 8'h0b;
  localparam logic [7:0] CDP_CMD_APPEND_ROW = 8'h0c;
  // Byte positions within a command, length byte is position 0
  localparam logic [7:0] CDP_POS_CODE = 8'h01;
  localparam logic [7:0] CDP_POS_ID_HI = 8'h02;
  localparam logic [7:0] CDP_POS_ID_LO = 8'h03;
  localparam logic [7:0] CDP_POS_ARG_LO = 8'h04;
  localparam logic [7:0] CDP_POS_ARG_HI = 8'h05;
  localparam logic [7:0] CDP_POS_DATA = 8'h06;
  localparam logic [7:0] CDP_POS_ROW_DATA = 8'h04;
  localparam logic [7:0] CDP_HDR_LEN = 8'h04;
  localparam logic [7:0] CDP_MIN_LEN = 8'h02;
  localparam int CDP_DATA_BYTES = 64;
  localparam int CDP_ROW_BYTES = 16;
  localparam int CDP_ROWS = 8;
  localparam int CDP_DT_AXIS_BYTES = 8;
  localparam logic [7:0] CDP_STATE_OFF = 8'h00;
  localparam logic [7:0] CDP_STATE_ON = 8'hff;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cdp_byte_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] ctrl_id;
  } cdp_event_t;
endpackage : cdp_pkg

// *** logic/cdp_field_reg.sv ***
// Module: little-endian two-byte field assembler
`timescale 1ns/100ps
module cdp_field_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Byte capture
  input wire logic clear,
  input wire logic load_lo,
  input wire logic load_hi,
  input wire logic [7:0] din,
  // Assembled value
  output logic [15:0] value
);
  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      value <= 16'h0000;
    end else if (load_lo) begin
      value[7:0] <= din;
    end else if (load_hi) begin
      value[15:8] <= din;
    end
  end
endmodule : cdp_field_reg

// *** logic/cdp_row_store.sv ***
// Module: circular row store with append, indexed write and top-row discard
`timescale 1ns/100ps
module cdp_row_store #(
  parameter int ROW_BYTES = 16,
  parameter int ROWS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Byte writes
  input wire logic wr_en,
  input wire logic wr_append,
  input wire logic [15:0] wr_row,
  input wire logic [$clog2(ROW_BYTES)-1:0] wr_byte,
  input wire logic [7:0] wr_data,
  // Row commit for appends
  input wire logic append_done,
  // Status
  output logic [$clog2(ROWS+1)-1:0] row_count,
  output logic [$clog2(ROWS)-1:0] head
);
  localparam int RW = $clog2(ROWS);
  initial begin
    if (ROWS < 2 || (ROWS & (ROWS - 1)) != 0) $error("ROWS must be a power of two");
  end
  logic [7:0] mem [ROWS][ROW_BYTES];
  logic [RW-1:0] tail;
  logic [RW-1:0] wr_slot;

  assign tail = head + RW'(row_count);
  assign wr_slot = wr_append ? tail : head + wr_row[RW-1:0];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_slot][wr_byte] <= wr_data;
    end
  end

  // Full store drops its oldest row by moving the head
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      head <= '0;
      row_count <= '0;
    end else if (append_done) begin
      if (row_count == ($clog2(ROWS+1))'(ROWS)) begin
        head <= head + 1'b1;
      end else begin
        row_count <= row_count + 1'b1;
      end
    end else if (wr_en && !wr_append && wr_row < 16'(ROWS)
                 && ($clog2(ROWS+1))'(wr_row) >= row_count) begin
      row_count <= ($clog2(ROWS+1))'(wr_row) + 1'b1;
    end
  end
endmodule : cdp_row_store

// *** bench/cdp_parser_monitor.sv ***
// Checker: notification timing, event fields and matrix occupancy of the parser
`timescale 1ns/100ps
module cdp_parser_monitor
  import cdp_pkg::*;
#(
  parameter int ROWS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Stream and status
  input cdp_pkg::cdp_byte_t rx,
  input wire logic client_connected,
  input wire logic send_pulse,
  input cdp_pkg::cdp_event_t send_event,
  input wire logic [15:0] last_row,
  input wire logic [$clog2(ROWS+1)-1:0] row_count,
  input wire logic [$clog2(ROWS)-1:0] row_head
);
  logic [7:0] pos_reg, len_reg, code_reg, off_reg;
  logic [15:0] id_reg;
  logic [7:0] code_w;
  logic [7:0] off_w;
  logic last_w, due_w, app_w;
  // A two-byte command ends on its code byte, before code_reg is loaded
  assign code_w = (pos_reg == CDP_POS_CODE) ? rx.data : code_reg;
  assign last_w = rx.valid && pos_reg != 8'h00 && pos_reg == len_reg - 8'h01;
  assign off_w = (pos_reg == CDP_POS_ARG_HI) ? (off_reg | rx.data) : off_reg;
  assign app_w = last_w && code_w == CDP_CMD_APPEND_ROW;
  assign due_w = last_w && ((code_w == CDP_CMD_SET_DATA && off_w == 8'h00
    && pos_reg >= CDP_POS_ARG_HI)
    || (code_w == CDP_CMD_SET_ROW && len_reg == CDP_HDR_LEN) || (app_w && client_connected));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_reg <= 8'h00;
    end else if (rx.valid) begin
      if (last_w || (pos_reg == 8'h00 && rx.data < CDP_MIN_LEN)) begin
        pos_reg <= 8'h00;
      end else begin
        pos_reg <= pos_reg + 8'h01;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rx.valid) begin
      case (pos_reg)
        8'h00: len_reg <= rx.data;
        CDP_POS_CODE: code_reg <= rx.data;
        CDP_POS_ID_HI: id_reg[15:8] <= rx.data;
        CDP_POS_ID_LO: id_reg[7:0] <= rx.data;
        CDP_POS_ARG_LO: off_reg <= rx.data;
        CDP_POS_ARG_HI: off_reg <= off_reg | rx.data;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  commit_notify_a: assert property (
    last_w && code_w == CDP_CMD_SET_DATA && off_w == 8'h00 && pos_reg >= CDP_POS_ARG_HI
    |=> send_pulse)
    else $error("no notify after zero-offset chunk");
  header_refresh_a: assert property (
    last_w && code_w == CDP_CMD_SET_ROW && len_reg == CDP_HDR_LEN |=> send_pulse)
    else $error("no notify after header-only row command");
  append_notify_a: assert property (app_w && client_connected |=> send_pulse)
    else $error("no notify after append");
  stray_pulse_a: assert property (send_pulse |-> $past(due_w))
    else $error("notify without cause");
  event_fields_a: assert property (
    send_pulse |-> send_event.cmd == code_reg && send_event.ctrl_id == id_reg)
    else $error("event carries wrong code or id");
  event_hold_a: assert property (!send_pulse |-> $stable(send_event))
    else $error("event changed without notify");
  append_grow_a: assert property (
    app_w && row_count < ROWS |=> row_count == $past(row_count) + 1'b1)
    else $error("append did not add a row");
  full_drop_a: assert property (
    app_w && row_count == ROWS |=> row_count == ROWS && row_head == $past(row_head) + 1'b1)
    else $error("full append did not drop top row");
  append_slot_a: assert property (
    app_w && client_connected && row_count < ROWS |=> last_row == $past(row_count))
    else $error("append slot index wrong");
endmodule : cdp_parser_monitor

bind cdp_parser cdp_parser_monitor #(.ROWS(ROWS)) i_cdp_parser_monitor (.clk, .sys_rst, .rx,
  .client_connected, .send_pulse, .send_event, .last_row, .row_count, .row_head);

// *** bench/cdp_host_model.sv ***
// Host model: sends command bytes on the byte stream
`timescale 1ns/100ps
module cdp_host_model
  import cdp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Byte stream
  output cdp_pkg::cdp_byte_t rx
);
  initial rx = '{valid: 1'b0, data: 8'h00};
  // Caller builds length byte first, code second; gap makes a slow host
  task automatic send(input logic [7:0] q[$], input int gap);
    foreach (q[i]) begin
      repeat ((i == 0) ? 0 : gap) begin
        @(negedge clk);
        rx <= '{valid: 1'b0, data: ~rx.data};
      end
      @(negedge clk);
      rx <= '{valid: 1'b1, data: q[i]};
    end
  endtask : send
  // Released line shows inverted data, never a stale byte
  task automatic idle();
    @(negedge clk);
    rx <= '{valid: 1'b0, data: ~rx.data};
  endtask : idle
endmodule : cdp_host_model

// *** bench/cdp_parser_bench.sv ***
// Bench: command sequences into the parser, checks of stored data and notifications
`timescale 1ns/100ps
module cdp_parser_bench;
  import cdp_pkg::*;
  logic clk, sys_rst, client_connected, send_pulse, cmd_error;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  cdp_byte_t rx;
  cdp_event_t send_event;
  logic [15:0] last_row;
  logic [3:0] row_count;
  logic [2:0] row_head;
  logic [7:0] q[$];
  int n_mismatch = 0, checked = 0, n_pulse = 0, n_err = 0;
  cdp_host_model i_cdp_host_model (.clk, .rx);
  cdp_parser i_cdp_parser (.clk, .sys_rst, .rx, .client_connected, .matrix_is_datetime(1'b0),
    .x_axis_bytes(8'h02), .rd_addr, .rd_data, .send_pulse, .send_event, .last_row,
    .row_count, .row_head, .cmd_error);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (send_pulse === 1'b1) n_pulse++;
    if (cmd_error === 1'b1) n_err++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic cmd(input logic [7:0] c[$], input int gap);
    i_cdp_host_model.send(c, gap);
    i_cdp_host_model.idle();
    repeat (3) @(negedge clk);
  endtask : cmd
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_addr <= a;
    @(negedge clk);
    check(rd_data, exp);
  endtask : rd_chk
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (10) @(negedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check({send_pulse, cmd_error, row_count, row_head}, 0);
  endtask : do_reset
  task automatic t_number();
    int p = n_pulse;
    cmd('{8'h0a, 8'h0a, 8'h00, 8'h02, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h80}, 0);
    check(n_pulse - p, 1);
    check(send_event, {CDP_CMD_SET_DATA, 16'h0002});
    rd_chk(6'h00, 8'h05);
    rd_chk(6'h03, 8'h80);
    cmd('{8'h07, 8'h0a, 8'h00, 8'h03, 8'h00, 8'h00, CDP_STATE_ON}, 0);
    rd_chk(6'h00, CDP_STATE_ON);
  endtask : t_number
  task automatic t_chunks();
    int p = n_pulse;
    q = '{8'h11, 8'h0a, 8'h07, 8'h05, 8'h10, 8'h00};
    for (int i = 0; i < 10; i++) q.push_back(8'(8'h51 + i));
    q.push_back(8'h00);
    cmd(q, 0);
    check(n_pulse - p, 0);
    rd_chk(6'h00, CDP_STATE_ON);
    q = '{8'h16, 8'h0a, 8'h07, 8'h05, 8'h00, 8'h00};
    for (int i = 0; i < 16; i++) q.push_back(8'(8'h41 + i));
    cmd(q, 2);
    check(n_pulse - p, 1);
    check(send_event, {CDP_CMD_SET_DATA, 16'h0705});
    rd_chk(6'h0f, 8'h50);
    rd_chk(6'h10, 8'h51);
    rd_chk(6'h1a, 8'h00);
  endtask : t_chunks
  task automatic t_rows();
    int p = n_pulse;
    int e = n_err;
    // Rows written in order; an index past the last row is the refused case
    for (int r = 0; r < 2; r++) begin
      cmd('{8'h0b, 8'h0b, 8'h00, 8'h02, 8'(r), 8'h00, 8'h21, 8'h00, 8'h06, 8'h07, 8'h08}, 0);
    end
    check(n_pulse - p, 0);
    cmd('{8'h0b, 8'h0b, 8'h00, 8'h02, 8'h08, 8'h00, 8'h21, 8'h00, 8'h06, 8'h07, 8'h08}, 0);
    // Each of the five refused row bytes raises its own error pulse
    check(n_err - e, 5);
    i_cdp_host_model.send('{8'h07, 8'h0d, 8'h00, 8'h02, 8'h06, 8'h07, 8'h08}, 0);
    cmd('{8'h04, 8'h0b, 8'h00, 8'h02}, 0);
    check(n_pulse - p, 1);
    check(send_event, {CDP_CMD_SET_ROW, 16'h0002});
  endtask : t_rows
  task automatic t_append();
    int p;
    // Fresh matrix: no indexed row writes follow these appends
    do_reset();
    client_connected <= 1'b1;
    p = n_pulse;
    for (int k = 0; k < 10; k++) begin
      if (k == 9) client_connected <= 1'b0;
      cmd('{8'h09, 8'h0c, 8'h00, 8'h02, 8'h21, 8'h00, 8'h06, 8'h07, 8'(k)}, 0);
      check(row_count, (k < 8) ? k + 1 : 8);
      check(n_pulse - p, (k < 9) ? k + 1 : 9);
      if (k < 8) check(last_row, k);
    end
    check(row_head, 2);
  endtask : t_append
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    client_connected = 1'b0;
    rd_addr = 6'h00;
    do_reset();
    t_number();
    t_chunks();
    t_rows();
    t_append();
    give_verdict();
  end
endmodule : cdp_parser_bench
